// File: logic/phs_pkg.sv
package phs_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CORE_PERIOD_NS = 10;
  localparam int SUSPEND_DELAY_US = 2000;
  localparam int SUSPEND_DELAY_CYC = SUSPEND_DELAY_US * 1000 / CORE_PERIOD_NS;
  localparam int INT_PULSE_NS = 166;
  localparam int INT_PULSE_CYC = (INT_PULSE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int SLOW_CLK_HZ = 115000;
  localparam int SLOW_HALF_CYC = 1000000000 / (CORE_PERIOD_NS * 2 * SLOW_CLK_HZ);
  localparam int CLOCK_OUTPUT_PIN_UNIT_CYC = 2;

  // ==========================================================
  // Command codes and transfer lengths
  // ==========================================================
  localparam logic [7:0] CMD_MODE_WR = 8'hb8;
  localparam logic [7:0] CMD_MODE_RD = 8'hb9;
  localparam logic [7:0] CMD_HW_WR = 8'hba;
  localparam logic [7:0] CMD_HW_RD = 8'hbb;
  localparam logic [7:0] CMD_IE_WR = 8'hc2;
  localparam logic [7:0] CMD_IE_RD = 8'hc3;
  localparam logic [1:0] MODE_LAST_BYTE = 2'h0;
  localparam logic [1:0] HW_LAST_BYTE = 2'h1;
  localparam logic [1:0] IE_LAST_BYTE = 2'h3;

  // ==========================================================
  // Reset values, writable masks, bit positions
  // ==========================================================
  localparam logic [15:0] HW_RESET = 16'h2344;
  localparam logic [15:0] HW_WMASK = 16'h7fef;
  localparam logic [31:0] IE_RESET = 32'h0000_0000;
  localparam logic [31:0] IE_WMASK = 32'h00ff_ff7f;
  localparam logic [7:0] MODE_RESET = 8'h80;
  localparam int MODE_SUSP_BIT = 5;
  localparam int MODE_INTENA_BIT = 3;
  localparam int MODE_SOFTCT_BIT = 0;

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic reserved_hi;
    logic external_pullup_select;
    logic no_slow_clock_out;
    logic clock_keep_running;
    logic [3:0] clock_out_divider;
    logic ack_only_dma_mode;
    logic dma_request_polarity;
    logic dma_ack_polarity;
    logic reserved_4;
    logic wake_on_select;
    logic spare_2;
    logic interrupt_pulse_mode;
    logic interrupt_polarity;
  } phs_hw_setup_t;

  typedef struct packed {
    logic cmd_strobe;
    logic data_wr;
    logic data_rd;
    logic [7:0] data;
  } phs_host_req_t;

  typedef enum logic [1:0] {
    SUSP_ACTIVE = 2'b00,
    SUSP_WAIT = 2'b01,
    SUSP_ASLEEP = 2'b11,
    SUSP_WAKE = 2'b10
  } phs_susp_t;

endpackage

// File: logic/phs_periph_hw_setup.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - External pull-up set: never drive internal pull-up
// - No-slow-clock set: no slow clock in suspend
// - Otherwise slow clock on pin after delay
// - Keep-running set: oscillator stays on always
// - Keep-running clear: oscillator off after delay
// - Clock pin period: divider field plus one, times two cycles
// - Divider resets to three
// - Divider change takes effect glitch free
// - Bit 7 selects ack-only or classic DMA
// - Bits 6, 5 set request, ack polarity
// - Wake-on-select: low select wakes from suspend
// - Interrupt level or fixed pulse per bit 1
// - Bit 0 sets interrupt pin polarity
// - Bus reset keeps hardware setup fields
// - Per-source interrupt enables gate sources
// - Bus reset keeps interrupt enables
// - Suspend begins on request one then zero
// - Setup register moves as two bytes
module phs_periph_hw_setup
  import phs_pkg::*;
#(
  parameter int SUSPEND_DELAY = SUSPEND_DELAY_CYC,
  parameter int NUM_SRC = 32
) (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // Host command port
  input wire phs_host_req_t host_req_i,
  output logic [7:0] host_rdata_o,
  // Core events
  input wire logic [NUM_SRC-1:0] int_src_i,
  input wire logic dma_need_i,
  input wire logic usb_bus_reset_i,
  input wire logic resume_i,
  // Pins
  input wire logic chip_sel_n_i,
  input wire logic periph_dma_ack_pin_i,
  output logic periph_dma_request_pin_o,
  output logic periph_interrupt_pin_o,
  output logic clock_output_pin_o,
  // Core controls
  output logic soft_pullup_o,
  output logic osc_enable_o,
  output logic suspended_o,
  output logic wakeup_o,
  output logic dma_ack_active_o
);

  localparam int SW = $clog2(SUSPEND_DELAY + 1);
  localparam int DW = 8;
  localparam int PW = $clog2(INT_PULSE_CYC + 1);
  localparam int LW = $clog2(SLOW_HALF_CYC + 1);
  localparam logic [SW-1:0] SUSP_LAST = SW'(SUSPEND_DELAY - 1);
  localparam logic [PW-1:0] PULSE_LOAD = PW'(INT_PULSE_CYC);
  localparam logic [LW-1:0] SLOW_LAST = LW'(SLOW_HALF_CYC - 1);

  // ==========================================================
  // Host register access
  // ==========================================================
  logic [7:0] cmd_q, cmd_d;
  logic [1:0] idx_q, idx_d;
  logic [31:0] stage_q, stage_d;
  phs_hw_setup_t hw_q, hw_d;
  logic [31:0] ie_q, ie_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] rdata_q, rdata_d;
  logic susp_go;

  // Byte-serial access, low byte first; commit on last byte
  always_comb begin
    cmd_d = cmd_q;
    idx_d = idx_q;
    stage_d = stage_q;
    hw_d = hw_q;
    ie_d = ie_q;
    mode_d = mode_q;
    rdata_d = rdata_q;
    susp_go = 1'b0;
    if (host_req_i.cmd_strobe) begin
      cmd_d = host_req_i.data;
      idx_d = 2'h0;
    end else if (host_req_i.data_wr) begin
      stage_d[{idx_q, 3'b000} +: 8] = host_req_i.data;
      idx_d = idx_q + 2'h1;
      // A partial write leaves the register untouched
      if (cmd_q == CMD_HW_WR && idx_q == HW_LAST_BYTE) begin
        hw_d = stage_d[15:0] & HW_WMASK;
      end
      if (cmd_q == CMD_IE_WR && idx_q == IE_LAST_BYTE) begin
        ie_d = stage_d & IE_WMASK;
      end
      if (cmd_q == CMD_MODE_WR && idx_q == MODE_LAST_BYTE) begin
        mode_d = host_req_i.data;
        susp_go = mode_q[MODE_SUSP_BIT] & ~mode_d[MODE_SUSP_BIT];
      end
    end else if (host_req_i.data_rd) begin
      idx_d = idx_q + 2'h1;
      unique case (cmd_q)
        CMD_HW_RD: rdata_d = hw_q[{idx_q[0], 3'b000} +: 8];
        CMD_IE_RD: rdata_d = ie_q[{idx_q, 3'b000} +: 8];
        CMD_MODE_RD: rdata_d = mode_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Only the power-on reset restores these; bus reset is ignored
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cmd_q <= 8'h00;
      idx_q <= 2'h0;
      stage_q <= 32'h0000_0000;
      hw_q <= HW_RESET;
      ie_q <= IE_RESET;
      mode_q <= MODE_RESET;
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      cmd_q <= cmd_d;
      idx_q <= idx_d;
      stage_q <= stage_d;
      hw_q <= hw_d;
      ie_q <= ie_d;
      mode_q <= mode_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [1:0] cs_sync_q, ack_sync_q;

  // Second stage only is read by logic
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cs_sync_q <= 2'b11;
      ack_sync_q <= 2'b00;
    end else if (ce_i) begin
      cs_sync_q <= {cs_sync_q[0], chip_sel_n_i};
      ack_sync_q <= {ack_sync_q[0], periph_dma_ack_pin_i};
    end
  end

  // ==========================================================
  // Suspend sequencing
  // ==========================================================
  phs_susp_t st_q, st_d;
  logic [SW-1:0] scnt_q, scnt_d;
  logic wake_req;
  logic osc_q, osc_d, susp_q, susp_d, wake_q, wake_d;

  always_comb begin
    // Bus reset or resume also ends suspend
    wake_req = (hw_q.wake_on_select & ~cs_sync_q[1]) | resume_i | usb_bus_reset_i;
    st_d = st_q;
    scnt_d = scnt_q;
    unique case (st_q)
      SUSP_ACTIVE: begin
        if (susp_go) begin
          st_d = SUSP_WAIT;
          scnt_d = '0;
        end
      end
      SUSP_WAIT: begin
        scnt_d = scnt_q + SW'(1);
        if (wake_req) begin
          st_d = SUSP_WAKE;
        end else if (scnt_q == SUSP_LAST) begin
          st_d = SUSP_ASLEEP;
        end
      end
      SUSP_ASLEEP: begin
        if (wake_req) begin
          st_d = SUSP_WAKE;
        end
      end
      SUSP_WAKE: st_d = SUSP_ACTIVE;
    endcase
    // Software must clear keep-running for suspend current
    osc_d = ~(st_d == SUSP_ASLEEP) | hw_q.clock_keep_running;
    susp_d = (st_d == SUSP_ASLEEP);
    wake_d = (st_d == SUSP_WAKE);
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      st_q <= SUSP_ACTIVE;
      scnt_q <= '0;
      osc_q <= 1'b1;
      susp_q <= 1'b0;
      wake_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d;
      scnt_q <= scnt_d;
      osc_q <= osc_d;
      susp_q <= susp_d;
      wake_q <= wake_d;
    end
  end

  // ==========================================================
  // Clock output divider
  // ==========================================================
  logic [3:0] divn_q, divn_d;
  logic [DW-1:0] dcnt_q, dcnt_d, per_last, half;
  logic [LW-1:0] lcnt_q, lcnt_d;
  logic slow_q, slow_d, clko_q, clko_d;

  // New divider is only taken at a period boundary, so no runt
  always_comb begin
    per_last = DW'((int'(divn_q) + 1) * CLOCK_OUTPUT_PIN_UNIT_CYC - 1);
    half = DW'(((int'(divn_q) + 1) * CLOCK_OUTPUT_PIN_UNIT_CYC) / 2);
    divn_d = divn_q;
    dcnt_d = dcnt_q + DW'(1);
    if (dcnt_q == per_last) begin
      dcnt_d = '0;
      divn_d = hw_q.clock_out_divider;
    end
    lcnt_d = lcnt_q + LW'(1);
    slow_d = slow_q;
    if (lcnt_q == SLOW_LAST) begin
      lcnt_d = '0;
      slow_d = ~slow_q;
    end
    if (st_q == SUSP_ASLEEP) begin
      clko_d = slow_q & ~hw_q.no_slow_clock_out;
    end else begin
      clko_d = (dcnt_q < half);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      divn_q <= HW_RESET[11:8];
      dcnt_q <= '0;
      lcnt_q <= '0;
      slow_q <= 1'b0;
      clko_q <= 1'b0;
    end else if (ce_i) begin
      divn_q <= divn_d;
      dcnt_q <= dcnt_d;
      lcnt_q <= lcnt_d;
      slow_q <= slow_d;
      clko_q <= clko_d;
    end
  end

  // ==========================================================
  // Interrupt pin
  // ==========================================================
  logic ireq, ireq_q, pend_q, pend_d, ipin_q, ipin_d, iact;
  logic [PW-1:0] pcnt_q, pcnt_d;

  // A request edge during a pulse is held and served afterwards
  always_comb begin
    ireq = mode_q[MODE_INTENA_BIT] & (|(int_src_i & ie_q[NUM_SRC-1:0]));
    pend_d = pend_q | (ireq & ~ireq_q);
    pcnt_d = pcnt_q;
    if (pcnt_q != '0) begin
      pcnt_d = pcnt_q - PW'(1);
    end else if (pend_q) begin
      pcnt_d = PULSE_LOAD;
      pend_d = ireq & ~ireq_q;
    end
    if (!hw_q.interrupt_pulse_mode) begin
      pend_d = 1'b0;
      pcnt_d = '0;
    end
    iact = hw_q.interrupt_pulse_mode ? (pcnt_d != '0) : ireq;
    ipin_d = iact ~^ hw_q.interrupt_polarity;
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ireq_q <= 1'b0;
      pend_q <= 1'b0;
      pcnt_q <= '0;
      ipin_q <= 1'b1;
    end else if (ce_i) begin
      ireq_q <= ireq;
      pend_q <= pend_d;
      pcnt_q <= pcnt_d;
      ipin_q <= ipin_d;
    end
  end

  // ==========================================================
  // DMA handshake and pull-up
  // ==========================================================
  logic dreq_q, dreq_d, dack_q, dack_d, pull_q, pull_d, ack_act;

  // Ack-only mode never raises a request; the ack alone moves data
  always_comb begin
    ack_act = ack_sync_q[1] ~^ hw_q.dma_ack_polarity;
    dreq_d = (dma_need_i & ~hw_q.ack_only_dma_mode) ~^ hw_q.dma_request_polarity;
    dack_d = ack_act & (hw_q.ack_only_dma_mode | dma_need_i);
    pull_d = mode_q[MODE_SOFTCT_BIT] & ~hw_q.external_pullup_select;
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      dreq_q <= 1'b0;
      dack_q <= 1'b0;
      pull_q <= 1'b0;
    end else if (ce_i) begin
      dreq_q <= dreq_d;
      dack_q <= dack_d;
      pull_q <= pull_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign host_rdata_o = rdata_q;
  assign periph_dma_request_pin_o = dreq_q;
  assign periph_interrupt_pin_o = ipin_q;
  assign clock_output_pin_o = clko_q;
  assign soft_pullup_o = pull_q;
  assign osc_enable_o = osc_q;
  assign suspended_o = susp_q;
  assign wakeup_o = wake_q;
  assign dma_ack_active_o = dack_q;

endmodule
`default_nettype wire

// File: logic/phs_unused_guard.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: verification/phs_periph_hw_setup_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// Checker
module phs_periph_hw_setup_chk
  import phs_pkg::*;
(
  // Clock, reset, host port
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire phs_host_req_t host_req_i,
  input wire logic [7:0] host_rdata_o,
  // Events and pins
  input wire logic dma_need_i,
  input wire logic chip_sel_n_i,
  input wire logic periph_dma_request_pin_o,
  input wire logic periph_interrupt_pin_o,
  input wire logic clock_output_pin_o,
  // Core controls
  input wire logic soft_pullup_o,
  input wire logic osc_enable_o,
  input wire logic suspended_o,
  input wire logic wakeup_o,
  input wire logic dma_ack_active_o
);
  logic [7:0] cmd_q, lo_q;
  logic idx_q;
  logic [15:0] hw_q;
  logic [5:0] age_q, run_q, hi_q;
  wire hw_wr = host_req_i.data_wr && !host_req_i.cmd_strobe && cmd_q == CMD_HW_WR;
  wire int_act = periph_interrupt_pin_o == hw_q[0];
  wire exp_dreq = hw_q[6] ~^ (!hw_q[7] && dma_need_i);
  // Shadow setup register; age holds off checks while old settings drain out
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cmd_q <= 8'h00;
      idx_q <= 1'b0;
      hw_q <= HW_RESET;
      age_q <= 6'h00;
      run_q <= 6'h00;
      hi_q <= 6'h00;
    end else if (ce_i) begin
      if (host_req_i.cmd_strobe) begin
        cmd_q <= host_req_i.data;
        idx_q <= 1'b0;
      end else if (hw_wr) begin
        idx_q <= !idx_q;
        lo_q <= host_req_i.data;
      end
      if (hw_wr && idx_q) hw_q <= {host_req_i.data, lo_q} & HW_WMASK;
      age_q <= (hw_wr || suspended_o) ? 6'h00 : age_q + 6'(age_q != 6'h3f);
      run_q <= int_act ? run_q + 6'h01 : 6'h00;
      hi_q <= clock_output_pin_o ? hi_q + 6'h01 : 6'h00;
    end
  end

  // ========
  // Properties
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i || !ce_i);
  sequence s_wake;
    wakeup_o ##1 (!wakeup_o && !suspended_o);
  endsequence
  chk_pullup_ext: assert property (hw_q[14] && $past(hw_q[14]) |=> !soft_pullup_o)
    else $error("internal pull-up driven with external pull-up");
  chk_dreq_level: assert property ($stable(hw_q) |=> periph_dma_request_pin_o == $past(exp_dreq))
    else $error("dma request pin wrong level");
  chk_osc_asleep: assert property (!osc_enable_o |-> suspended_o && !hw_q[12])
    else $error("oscillator off outside allowed sleep");
  chk_rdata_hold: assert property (!host_req_i.data_rd |=> $stable(host_rdata_o))
    else $error("read byte changed without a read");
  chk_wake_pulse: assert property ($rose(wakeup_o) |-> s_wake)
    else $error("wake pulse malformed");
  chk_wake_cs: assert property (suspended_o && hw_q[3] && !chip_sel_n_i |-> ##[1:6] wakeup_o)
    else $error("select low did not wake");
  chk_int_pulse: assert property (hw_q[1] && age_q > 6'd40 && $fell(int_act) |-> run_q == 6'(INT_PULSE_CYC))
    else $error("interrupt pulse width wrong");
  chk_clk_high: assert property (($fell(clock_output_pin_o) && age_q > 6'd40 ##1 !suspended_o)
    |-> $past(hi_q) == {2'b00, hw_q[11:8]} + 6'h01)
    else $error("clock output high time wrong");
  // Classic mode: no demand means no acknowledge is passed on
  chk_dack_need: assert property ($stable(hw_q) && !hw_q[7] && !dma_need_i |=> !dma_ack_active_o)
    else $error("dma ack passed on without demand");
endmodule

bind phs_periph_hw_setup phs_periph_hw_setup_chk i_chk (
  .core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i),
  .ce_i(ce_i),
  .host_req_i(host_req_i),
  .host_rdata_o(host_rdata_o),
  .dma_need_i(dma_need_i),
  .chip_sel_n_i(chip_sel_n_i),
  .periph_dma_request_pin_o(periph_dma_request_pin_o),
  .periph_interrupt_pin_o(periph_interrupt_pin_o),
  .clock_output_pin_o(clock_output_pin_o),
  .soft_pullup_o(soft_pullup_o),
  .osc_enable_o(osc_enable_o),
  .suspended_o(suspended_o),
  .wakeup_o(wakeup_o),
  .dma_ack_active_o(dma_ack_active_o)
);
`default_nettype wire

// File: verification/phs_dma_model.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// DMA controller model
module phs_dma_model (
  // Clock and settings
  input wire logic core_clk_i,
  input wire logic drq_pol_i,
  input wire logic ack_pol_i,
  input wire logic slow_i,
  // Pins
  input wire logic periph_dma_request_pin_i,
  output logic periph_dma_ack_pin_o
);
  logic [2:0] wait_q = 3'h0;
  // Count request cycles; slow mode grants late like a busy controller
  always @(posedge core_clk_i) begin
    wait_q <= (periph_dma_request_pin_i == drq_pol_i) ? wait_q + 3'(wait_q != 3'h7) : 3'h0;
  end
  assign periph_dma_ack_pin_o = ack_pol_i ~^ (wait_q > (slow_i ? 3'h3 : 3'h0));
endmodule
`default_nettype wire

// File: verification/periph_hw_config_and_int_enable_tb.sv
`timescale 1ns/1ns
`default_nettype none
module periph_hw_config_and_int_enable_tb import phs_pkg::*;;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, dma_need_i = 1'b0, slow = 1'b0;
  logic usb_bus_reset_i = 1'b0, resume_i = 1'b0, chip_sel_n_i = 1'b1, rd_flag = 1'b0;
  logic [31:0] int_src_i = 32'h0;
  phs_host_req_t host_req_i = '0;
  logic [7:0] host_rdata_o;
  logic [15:0] v, hw = 16'h2344;
  logic periph_dma_ack_pin_i, periph_dma_request_pin_o, periph_interrupt_pin_o, clock_output_pin_o;
  logic soft_pullup_o, osc_enable_o, suspended_o, wakeup_o, dma_ack_active_o;
  logic [7:0] exp_q[$];
  integer seed = 32'hc421;
  int fail_count = 0, cmp_count = 0, n, k;

  // ========
  // Design and far side
  phs_periph_hw_setup #(.SUSPEND_DELAY(20), .NUM_SRC(32)) i_dut (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .host_req_i(host_req_i),
    .host_rdata_o(host_rdata_o),
    .int_src_i(int_src_i),
    .dma_need_i(dma_need_i),
    .usb_bus_reset_i(usb_bus_reset_i),
    .resume_i(resume_i),
    .chip_sel_n_i(chip_sel_n_i),
    .periph_dma_ack_pin_i(periph_dma_ack_pin_i),
    .periph_dma_request_pin_o(periph_dma_request_pin_o),
    .periph_interrupt_pin_o(periph_interrupt_pin_o),
    .clock_output_pin_o(clock_output_pin_o),
    .soft_pullup_o(soft_pullup_o),
    .osc_enable_o(osc_enable_o),
    .suspended_o(suspended_o),
    .wakeup_o(wakeup_o),
    .dma_ack_active_o(dma_ack_active_o)
  );
  phs_dma_model i_dma (.core_clk_i(core_clk_i), .drq_pol_i(hw[6]), .ack_pol_i(hw[5]), .slow_i(slow),
    .periph_dma_request_pin_i(periph_dma_request_pin_o), .periph_dma_ack_pin_o(periph_dma_ack_pin_i));
  always #5 core_clk_i = ~core_clk_i;
  // Random DMA demand keeps the request pin busy all run
  always @(posedge core_clk_i) begin
    #1;
    dma_need_i = $random(seed);
  end

  // ========
  // Tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk_i);
    #1;
  endtask
  // One-cycle strobe: 1 command, 2 write, 3 read, 0 idle
  task automatic op(input int s, input logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    host_req_i = '{s == 1, s == 2, s == 3, d};
  endtask
  task automatic wr_n(input logic [7:0] code, input logic [31:0] val, input int len);
    if (code == CMD_HW_WR) hw = val[15:0];
    op(1, code);
    for (int i = 0; i < len; i++) op(2, val[8*i+:8]);
    op(0, 8'h00);
  endtask
  task automatic rd_n(input logic [7:0] code, input logic [31:0] exp, input int len);
    for (int i = 0; i < len; i++) exp_q.push_back(exp[8*i+:8]);
    op(1, code);
    for (int i = 0; i < len; i++) op(3, 8'h00);
    op(0, 8'h00);
  endtask

  // ========
  // Read-back monitor: byte is valid in the cycle after the read strobe
  always @(posedge core_clk_i) rd_flag <= host_req_i.data_rd;
  always @(negedge core_clk_i) begin
    if (rd_flag) check("read byte", {8'h00, host_rdata_o}, exp_q.pop_front());
  end

  // ========
  // Scenarios
  initial begin
    tick(12);
    reset_n_i = 1'b1;
    rd_n(CMD_HW_RD, 32'h2344, 2);
    wr_n(CMD_MODE_WR, 32'h09, 1);
    for (n = 0; n < 6; n++) begin
      v = $random(seed);
      slow = n[0];
      wr_n(CMD_HW_WR, {16'h0, v}, 2);
      tick(50);
      rd_n(CMD_HW_RD, {16'h0, v & 16'h7fef}, 2);
    end
    wr_n(CMD_IE_WR, 32'hffff_ffff, 4);
    usb_bus_reset_i = 1'b1;
    tick(3);
    usb_bus_reset_i = 1'b0;
    rd_n(CMD_HW_RD, {16'h0, v & 16'h7fef}, 2);
    rd_n(CMD_IE_RD, 32'h00ff_ff7f, 4);
    wr_n(CMD_HW_WR, 32'h0040, 2);
    wr_n(CMD_IE_WR, 32'h1, 4);
    int_src_i = 32'h2;
    tick(5);
    check("masked int", {15'h0, periph_interrupt_pin_o}, 16'h1);
    int_src_i = 32'h1;
    tick(5);
    check("level int", {15'h0, periph_interrupt_pin_o}, 16'h0);
    int_src_i = 32'h0;
    wr_n(CMD_HW_WR, 32'h0043, 2);
    tick(50);
    int_src_i = 32'h1;
    k = 0;
    repeat (40) begin
      tick(1);
      k += periph_interrupt_pin_o;
    end
    check("pulse width", k[15:0], 16'h11);
    int_src_i = 32'h0;
    for (n = 0; n < 2; n++) begin
      wr_n(CMD_HW_WR, 32'h0348 | (32'(n) << 12), 2);
      wr_n(CMD_MODE_WR, 32'h29, 1);
      wr_n(CMD_MODE_WR, 32'h09, 1);
      tick(30);
      check("asleep", {15'h0, suspended_o}, 16'h1);
      check("oscillator", {15'h0, osc_enable_o}, 16'(n));
      chip_sel_n_i = n[0];
      resume_i = n[0];
      tick(8);
      check("woken", {15'h0, suspended_o}, 16'h0);
      chip_sel_n_i = 1'b1;
      resume_i = 1'b0;
    end
    tick(4);
    report_and_stop();
  end
  // Watchdog: the sequence needs about 600 cycles
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
